// >>> logic/mrsf_reset_ctrl.sv
// reset source combiner, start-up timer and reset flags with an axi4-lite slave
// assumes one 100 MHz clock; pin and supply inputs synchronous; options are static straps
// Operation
// - pin low while running resets program counter to zero, restart there.
// - shared pin acts as reset only when the reset option selects it.
// - low supply causes reset only when it lasts beyond the minimum time.
// - low supply reset enable and trip level come from options, not registers.
// - watchdog timeout when running acts like pin reset, plus timeout flag.
// - watchdog timeout in power-down clears only counter and stack pointer.
// - pin reset at power-on leaves both flags at zero.
// - pin wake from power-down clears both flags.
// - pin or low supply reset while running clears both flags.
// - watchdog timeout while running sets timeout flag, keeps power-down flag.
// - watchdog timeout in power-down sets both flags.
// - after power-on all interrupt sources are disabled.
// - after power-on the watchdog counter clears and counts at once.
// - after power-on timers are off and prescaler is cleared.
// - after power-on ports are inputs, data and direction all ones.
// - after power-on stack pointer addresses top of stack.
// - start-up timer delay follows reset release before execution.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mrsf_defines.svh"
module mrsf_reset_ctrl #(
    parameter int SST_CYC = `MRSF_SST_CYC,
    parameter int LVR_CYC = `MRSF_LVR_MIN_CYC,
    parameter int WDT_WIDTH = `MRSF_WDT_WIDTH,
    parameter int PORT_WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ext_reset_pin,
    input wire logic opt_pin_is_reset,
    input wire logic opt_low_supply_reset_en,
    input wire logic [1:0] opt_supply_trip_level,
    input wire logic [3:0] supply_below_level,
    output logic shared_port_pin_in,
    output logic core_reset,
    output logic core_run,
    output logic pc_clear,
    output logic sp_clear,
    output logic intr_disable,
    output logic timer_off,
    output logic [PORT_WIDTH-1:0] port_data_init,
    output logic [PORT_WIDTH-1:0] port_dir_init,
    output logic watchdog_timeout_flag,
    output logic powerdown_flag,
    output logic [WDT_WIDTH-1:0] watchdog_counter,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    mrsf_pkg::mrsf_state_t state_reg;
    logic [31:0] sst_cnt_reg;
    logic [31:0] lvr_cnt_reg;
    logic [WDT_WIDTH-1:0] wdt_reg;
    logic to_reg;
    logic pdf_reg;
    logic pd_wake_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic pin_low;
    logic supply_low;
    logic lvr_trip;
    logic wdt_trip;
    logic full_reset;
    logic [3:0] events;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic rd_stat_clear;
    logic kick;
    logic pd_req;
    logic wdt_force;

    assign pin_low = opt_pin_is_reset & ~ext_reset_pin;
    assign shared_port_pin_in = opt_pin_is_reset ? 1'b1 : ext_reset_pin;
    assign supply_low = supply_below_level[opt_supply_trip_level];

    // dip filter: only a low that outlasts the minimum time trips
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lvr_cnt_reg <= 32'h00000000;
        end else if (!(opt_low_supply_reset_en && supply_low)) begin
            lvr_cnt_reg <= 32'h00000000;
        end else if (lvr_cnt_reg <= LVR_CYC) begin
            lvr_cnt_reg <= lvr_cnt_reg + 32'h00000001;
        end
    end
    assign lvr_trip = lvr_cnt_reg > LVR_CYC;

    assign wdt_trip = (&wdt_reg) | wdt_force;
    assign full_reset = pin_low | lvr_trip |
        (wdt_trip && state_reg == mrsf_pkg::MRSF_ST_RUN);

    // the sequencer keeps the core held until the start-up timer runs out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= mrsf_pkg::MRSF_ST_HOLD;
            sst_cnt_reg <= 32'h00000000;
        end else if (full_reset) begin
            state_reg <= mrsf_pkg::MRSF_ST_HOLD;
            sst_cnt_reg <= 32'h00000000;
        end else begin
            case (state_reg)
                mrsf_pkg::MRSF_ST_HOLD: begin
                    state_reg <= mrsf_pkg::MRSF_ST_START;
                    sst_cnt_reg <= 32'h00000000;
                end
                mrsf_pkg::MRSF_ST_START: begin
                    if (sst_cnt_reg >= SST_CYC - 1) begin
                        state_reg <= mrsf_pkg::MRSF_ST_RUN;
                    end else begin
                        sst_cnt_reg <= sst_cnt_reg + 32'h00000001;
                    end
                end
                mrsf_pkg::MRSF_ST_RUN: begin
                    if (pd_req) begin
                        state_reg <= mrsf_pkg::MRSF_ST_PDOWN;
                    end
                end
                mrsf_pkg::MRSF_ST_PDOWN: begin
                    if (wdt_trip) begin
                        // partial wake-up, still waits out the start-up timer
                        state_reg <= mrsf_pkg::MRSF_ST_START;
                        sst_cnt_reg <= 32'h00000000;
                    end
                end
                default: begin
                    state_reg <= mrsf_pkg::MRSF_ST_HOLD;
                end
            endcase
        end
    end

    // the power-down flag survives a running watchdog reset, so it cannot tell a
    // partial wake from a full reset; this bit remembers which start-up is under way
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pd_wake_reg <= 1'b0;
        end else if (full_reset) begin
            pd_wake_reg <= 1'b0;
        end else if (wdt_trip && state_reg == mrsf_pkg::MRSF_ST_PDOWN) begin
            pd_wake_reg <= 1'b1;
        end else if (state_reg == mrsf_pkg::MRSF_ST_RUN) begin
            pd_wake_reg <= 1'b0;
        end
    end

    assign core_reset = state_reg == mrsf_pkg::MRSF_ST_HOLD ||
        (state_reg == mrsf_pkg::MRSF_ST_START && !pd_wake_reg);
    assign core_run = state_reg == mrsf_pkg::MRSF_ST_RUN;
    assign pc_clear = state_reg != mrsf_pkg::MRSF_ST_RUN &&
        state_reg != mrsf_pkg::MRSF_ST_PDOWN;
    assign sp_clear = pc_clear;
    assign intr_disable = core_reset;
    assign timer_off = core_reset;
    assign port_data_init = core_reset ? {PORT_WIDTH{1'b1}} : {PORT_WIDTH{1'b0}};
    assign port_dir_init = port_data_init;

    // watchdog: cleared by any full reset, counts right after it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdt_reg <= '0;
        end else if (full_reset || state_reg == mrsf_pkg::MRSF_ST_HOLD || kick) begin
            wdt_reg <= '0;
        end else if (wdt_trip) begin
            wdt_reg <= '0;
        end else begin
            wdt_reg <= wdt_reg + 1'b1;
        end
    end
    assign watchdog_counter = wdt_reg;

    // flags: pin and supply win over the watchdog; the watchdog wins over power-down and kick
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
        end else if (pin_low || lvr_trip) begin
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
        end else if (wdt_trip && state_reg == mrsf_pkg::MRSF_ST_PDOWN) begin
            to_reg <= 1'b1;
            pdf_reg <= 1'b1;
        end else if (wdt_trip && state_reg == mrsf_pkg::MRSF_ST_RUN) begin
            to_reg <= 1'b1;
        end else if (pd_req && state_reg == mrsf_pkg::MRSF_ST_RUN) begin
            pdf_reg <= 1'b1;
            to_reg <= 1'b0;
        end else if (kick) begin
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
        end
    end
    assign watchdog_timeout_flag = to_reg;
    assign powerdown_flag = pdf_reg;

    assign events[`MRSF_EV_PIN] = pin_low;
    assign events[`MRSF_EV_LVR] = lvr_trip;
    assign events[`MRSF_EV_WDT] = wdt_trip && state_reg == mrsf_pkg::MRSF_ST_RUN;
    assign events[`MRSF_EV_WDT_PD] = wdt_trip && state_reg == mrsf_pkg::MRSF_ST_PDOWN;

    // a set in the same cycle as the clearing read survives
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (rd_stat_clear ? 4'h0 : irq_stat_reg) | events;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    // control bits act as one-cycle strobes; mask is a plain register
    assign kick = wr_fire && awaddr_reg == `MRSF_ADDR_CTRL && wstrb_reg[0] &&
        wdata_reg[`MRSF_CTRL_WDT_KICK];
    assign pd_req = wr_fire && awaddr_reg == `MRSF_ADDR_CTRL && wstrb_reg[0] &&
        wdata_reg[`MRSF_CTRL_PDOWN];
    assign wdt_force = wr_fire && awaddr_reg == `MRSF_ADDR_CTRL && wstrb_reg[0] &&
        wdata_reg[`MRSF_CTRL_WDT_FORCE];
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_reg <= 4'h0;
        end else if (wr_fire && awaddr_reg == `MRSF_ADDR_IRQ_MASK && wstrb_reg[0]) begin
            irq_mask_reg <= wdata_reg[3:0];
        end
    end

    // axi4-lite read: one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_stat_clear = s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `MRSF_ADDR_IRQ_STAT;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `MRSF_ADDR_CTRL: s_axi_rdata <= 32'h00000000;
                `MRSF_ADDR_STAT: s_axi_rdata <= {29'h00000000, core_run, pdf_reg, to_reg};
                `MRSF_ADDR_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_reg};
                `MRSF_ADDR_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : mrsf_reset_ctrl

// >>> logic/mrsf_defines.svh
// constants of the reset source and flag block
// included by the block; definitions only
`ifndef MRSF_DEFINES_SVH
`define MRSF_DEFINES_SVH
`define MRSF_CLK_PERIOD_NS 10
`define MRSF_LVR_MIN_NS 1000
`define MRSF_LVR_MIN_CYC ((`MRSF_LVR_MIN_NS + `MRSF_CLK_PERIOD_NS - 1) / `MRSF_CLK_PERIOD_NS)
`define MRSF_SST_CYC 1024
`define MRSF_ADDR_CTRL 8'h00
`define MRSF_ADDR_STAT 8'h04
`define MRSF_ADDR_IRQ_STAT 8'h08
`define MRSF_ADDR_IRQ_MASK 8'h0C
`define MRSF_CTRL_WDT_KICK 0
`define MRSF_CTRL_PDOWN 1
`define MRSF_CTRL_WDT_FORCE 2
`define MRSF_STAT_TO 0
`define MRSF_STAT_PDF 1
`define MRSF_STAT_RUN 2
`define MRSF_EV_PIN 0
`define MRSF_EV_LVR 1
`define MRSF_EV_WDT 2
`define MRSF_EV_WDT_PD 3
`define MRSF_PORT_RESET 8'hFF
`define MRSF_WDT_WIDTH 16
`endif

// >>> logic/mrsf_pkg.sv
// types of the reset source and flag block
// assumes mrsf_defines.svh is on the include path
package mrsf_pkg;
    typedef enum logic [1:0] {
        MRSF_ST_HOLD = 2'b00,
        MRSF_ST_START = 2'b01,
        MRSF_ST_RUN = 2'b10,
        MRSF_ST_PDOWN = 2'b11
    } mrsf_state_t;
endpackage : mrsf_pkg

// >>> verif/mrsf_checker.sv
// assertions on the outputs of the reset source and flag block
// assumes it is bound into mrsf_reset_ctrl with the same parameters
`timescale 1ns/1ps
module mrsf_checker #(
    parameter int SST_CYC = 8,
    parameter int LVR_CYC = 4,
    parameter int WDT_WIDTH = 16,
    parameter int PORT_WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic ext_reset_pin,
    input wire logic opt_pin_is_reset,
    input wire logic opt_low_supply_reset_en,
    input wire logic [1:0] opt_supply_trip_level,
    input wire logic [3:0] supply_below_level,
    input wire logic shared_port_pin_in,
    input wire logic core_reset,
    input wire logic core_run,
    input wire logic pc_clear,
    input wire logic sp_clear,
    input wire logic intr_disable,
    input wire logic timer_off,
    input wire logic [PORT_WIDTH-1:0] port_data_init,
    input wire logic [PORT_WIDTH-1:0] port_dir_init,
    input wire logic watchdog_timeout_flag,
    input wire logic powerdown_flag,
    input wire logic [WDT_WIDTH-1:0] watchdog_counter
);
    localparam int HOLD_CYC = SST_CYC + 1;
    logic sel_low;
    assign sel_low = opt_low_supply_reset_en & supply_below_level[opt_supply_trip_level];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // five samples is one past the minimum of four that the bench sets
    sequence s_long_dip;
        sel_low [*5];
    endsequence
    // second cycle of a power-down wake, so the flags have settled
    sequence s_pd_start;
        pc_clear && !core_reset ##1 pc_clear;
    endsequence
    a_pin_reset: assert property (
        opt_pin_is_reset && !ext_reset_pin |=>
        core_reset && !watchdog_timeout_flag && !powerdown_flag) else $error("pin reset lost");
    a_port_pin: assert property (
        shared_port_pin_in == (opt_pin_is_reset | ext_reset_pin)) else $error("port pin level");
    a_long_dip: assert property (
        core_run ##0 s_long_dip |-> ##[0:3] core_reset) else $error("low supply ignored");
    a_start_len: assert property (
        $fell(core_reset) |-> $past(core_reset, HOLD_CYC)) else $error("start-up too short");
    a_run_after: assert property (
        $fell(core_reset) |-> core_run) else $error("no run after reset");
    a_init_outs: assert property (
        core_reset |-> intr_disable && timer_off && pc_clear && sp_clear
        && (&port_data_init) && (&port_dir_init)) else $error("init outputs wrong");
    a_wdt_counts: assert property (
        $rose(core_run) |=> $changed(watchdog_counter)) else $error("watchdog idle");
    a_to_effect: assert property (
        $rose(watchdog_timeout_flag) |-> ##[0:1] (pc_clear && sp_clear)) else $error("no clear");
    a_pd_keep: assert property (
        $rose(watchdog_timeout_flag) && core_reset |-> $stable(powerdown_flag))
        else $error("powerdown flag moved");
    a_pd_wake: assert property (
        s_pd_start |-> watchdog_timeout_flag && powerdown_flag && sp_clear && !timer_off)
        else $error("power-down wake wrong");
endmodule : mrsf_checker

// >>> verif/mrsf_switch.sv
// model of the reset switch with pull-up and of the supply comparators
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module mrsf_switch (
    input wire logic clock,
    output logic ext_reset_pin,
    output logic [3:0] supply_below_level
);
    // pull-up holds the pin high while the switch is open
    initial begin
        ext_reset_pin = 1'h1;
        supply_below_level = 4'h0;
    end
    task automatic press(input int n);
        ext_reset_pin <= 1'h0;
        repeat (n) @(posedge clock);
        ext_reset_pin <= 1'h1;
    endtask : press
    task automatic dip(input logic [3:0] m, input int n);
        supply_below_level <= m;
        repeat (n) @(posedge clock);
        supply_below_level <= 4'h0;
    endtask : dip
endmodule : mrsf_switch

// >>> verif/tb_top.sv
// self-checking bench of the reset source and flag block
// assumes short counts: start-up 8, low supply minimum 4, watchdog 10 bits
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic opt_pin_is_reset = 1'h1;
    logic opt_low_supply_reset_en = 1'h1;
    logic [1:0] opt_supply_trip_level = 2'h0;
    logic ext_reset_pin, core_run, irq, to_flag, pd_flag;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [3:0] supply_below_level, sel;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    mrsf_switch mrsf_switch_inst (.clock, .ext_reset_pin, .supply_below_level);
    mrsf_reset_ctrl #(.SST_CYC(8), .LVR_CYC(4), .WDT_WIDTH(10)) mrsf_reset_ctrl_inst (
        .clock, .reset_n, .ext_reset_pin, .opt_pin_is_reset, .opt_low_supply_reset_en,
        .opt_supply_trip_level, .supply_below_level, .shared_port_pin_in(), .core_reset(),
        .core_run, .pc_clear(), .sp_clear(), .intr_disable(), .timer_off(), .port_data_init(),
        .port_dir_init(), .watchdog_timeout_flag(to_flag), .powerdown_flag(pd_flag),
        .watchdog_counter(),
        .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    initial forever #5 clock = ~clock;
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic ok);
        samples_checked++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("wrong value at %0t: flag or response", $time);
        end
    endtask : chk
    // handshakes are judged on settled values before the edge that completes them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_take, w_take, b_take;
        logic [1:0] resp;
        b_take = 1'h0;
        resp = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= {3'($urandom), 1'h1};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 20 && !b_take; n++) begin
            @(negedge clock);
            aw_take = s_axi_awvalid && s_axi_awready;
            w_take = s_axi_wvalid && s_axi_wready;
            b_take = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge clock);
            if (aw_take) s_axi_awvalid <= 1'h0;
            if (w_take) s_axi_wvalid <= 1'h0;
            if (b_take) s_axi_bready <= 1'h0;
        end
        chk(b_take && resp === 2'h0);
    endtask : axi_wr
    // expected word and response are queued for the read monitor
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        logic ar_take, r_take;
        r_take = 1'h0;
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 20 && !r_take; n++) begin
            @(negedge clock);
            ar_take = s_axi_arvalid && s_axi_arready;
            r_take = s_axi_rvalid && s_axi_rready;
            @(posedge clock);
            if (ar_take) s_axi_arvalid <= 1'h0;
            if (r_take) s_axi_rready <= 1'h0;
        end
        if (!r_take) chk(1'h0);
    endtask : axi_rd
    task automatic wait_run();
        int n;
        n = 0;
        repeat (3) @(posedge clock);
        do begin
            @(negedge clock);
            n++;
        end while (core_run !== 1'h1 && n < 1500);
        @(posedge clock);
        chk(core_run);
    endtask : wait_run
    // read data stands until the edge that takes it, so look mid-cycle
    always @(negedge clock) begin
        if (s_axi_rvalid && s_axi_rready) begin
            samples_checked++;
            if (exp_q.size() == 0 || {s_axi_rresp, s_axi_rdata} !== exp_q[0]) begin
                mismatches++;
                $display("wrong value at %0t: read %h", $time, {s_axi_rresp, s_axi_rdata});
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        #100us;
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(32'hB07F));
        @(posedge clock);
        opt_supply_trip_level <= 2'($urandom_range(3, 0));
        repeat (4) @(posedge clock);
        reset_n <= 1'h1;
        sel = 4'h1 << opt_supply_trip_level;
        wait_run();
        axi_rd(8'h04, 34'h4);
        axi_rd(8'h0C, 34'h0);
        axi_rd(8'h10, {2'h2, 32'h0});
        axi_wr(8'h0C, 32'hF);
        mrsf_switch_inst.press(3);
        wait_run();
        chk(irq);
        axi_rd(8'h08, 34'h1);
        chk(!irq);
        axi_rd(8'h04, 34'h4);
        opt_pin_is_reset <= 1'h0;
        mrsf_switch_inst.press(3);
        opt_pin_is_reset <= 1'h1;
        axi_rd(8'h08, 34'h0);
        // four low samples is exactly the minimum and must not reset
        mrsf_switch_inst.dip(sel, 4);
        axi_rd(8'h08, 34'h0);
        mrsf_switch_inst.dip(~sel, 8);
        axi_rd(8'h08, 34'h0);
        opt_low_supply_reset_en <= 1'h0;
        mrsf_switch_inst.dip(sel, 8);
        opt_low_supply_reset_en <= 1'h1;
        axi_rd(8'h08, 34'h0);
        mrsf_switch_inst.dip(sel, 6);
        wait_run();
        axi_rd(8'h08, 34'h2);
        axi_rd(8'h04, 34'h4);
        axi_wr(8'h00, 32'h4);
        wait_run();
        axi_rd(8'h04, 34'h5);
        axi_rd(8'h08, 34'h4);
        axi_wr(8'h00, 32'h2);
        wait_run();
        axi_rd(8'h04, 34'h7);
        axi_rd(8'h08, 34'h8);
        axi_wr(8'h00, 32'h4);
        wait_run();
        axi_rd(8'h04, 34'h7);
        axi_wr(8'h00, 32'h2);
        mrsf_switch_inst.press(3);
        wait_run();
        axi_rd(8'h04, 34'h4);
        chk(to_flag === 1'h0 && pd_flag === 1'h0);
        axi_wr(8'h00, 32'h4);
        wait_run();
        chk(to_flag === 1'h1);
        // kick strobe clears the counter and both flags
        axi_wr(8'h00, 32'h1);
        axi_rd(8'h04, 34'h4);
        chk(to_flag === 1'h0 && pd_flag === 1'h0);
        results();
    end
endmodule : tb_top
bind mrsf_reset_ctrl mrsf_checker #(.SST_CYC(SST_CYC), .LVR_CYC(LVR_CYC),
    .WDT_WIDTH(WDT_WIDTH), .PORT_WIDTH(PORT_WIDTH)) mrsf_checker_inst (.clock, .reset_n,
    .ext_reset_pin, .opt_pin_is_reset, .opt_low_supply_reset_en, .opt_supply_trip_level,
    .supply_below_level, .shared_port_pin_in, .core_reset, .core_run, .pc_clear, .sp_clear,
    .intr_disable, .timer_off, .port_data_init, .port_dir_init, .watchdog_timeout_flag,
    .powerdown_flag, .watchdog_counter);
